// ==== adc_map.svh ====
`ifndef ADC_MAP_SVH
`define ADC_MAP_SVH

// Register indices on the plain register port
`define ADC_OFF_CTRL_A          3'h0
`define ADC_OFF_CTRL_B          3'h1
`define ADC_OFF_MUX_SEL         3'h2
`define ADC_OFF_RESULT_LOW      3'h3
`define ADC_OFF_RESULT_HIGH     3'h4
`define ADC_OFF_PIN_DISABLE     3'h5

// Control/status A field positions
`define ADC_A_ENABLE_BIT        7
`define ADC_A_START_BIT         6
`define ADC_A_AUTO_BIT          5
`define ADC_A_FLAG_BIT          4
`define ADC_A_IRQ_EN_BIT        3
`define ADC_A_PRESC_LSB         0

// Control/status B field positions
`define ADC_B_COMP_MUX_BIT      6
`define ADC_B_TRIG_LSB          0

// Mux select field positions
`define ADC_M_REF_LSB           6
`define ADC_M_LEFT_BIT          5
`define ADC_M_CHAN_LSB          0

// Reset values
`define ADC_RST_BYTE            8'h00
`define ADC_RST_RESULT          10'h000

// Timing counts, in converter clock cycles
`define ADC_NORMAL_CYCLES       5'd13
`define ADC_FIRST_CYCLES        5'd25

// Trigger source code that selects the own completion flag
`define ADC_TRIG_SELF           3'h0

`endif

// ==== adc_pkg.sv ====
`default_nettype none

package adc_pkg;

    // Conversion sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ALIGN = 3'b010,
        ST_CONV  = 3'b100
    } conv_state_t;

    // Register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // Prescaler state
    typedef struct packed {
        logic [6:0] cnt;
        logic       tick;
    } presc_state_t;

    // Whole state of the control block
    typedef struct packed {
        conv_state_t st;
        logic        en;
        logic        start;
        logic        ate;
        logic        flag;
        logic        ie;
        logic [2:0]  psel;
        logic        comparator_mux_enable;
        logic [2:0]  tsel;
        logic [1:0]  refsel;
        logic        lar;
        logic [2:0]  chan;
        logic [1:0]  didr;
        logic [1:0]  ref_applied;
        logic [2:0]  chan_applied;
        logic [9:0]  result;
        logic        lock;
        logic        first;
        logic [4:0]  tick_cnt;
        logic        trig_prev;
        logic [1:0]  pin_s1;
        logic [1:0]  pin_s2;
        logic [1:0]  pin_read;
        logic        irq;
        logic [7:0]  rdata;
        logic        comp_mux;
        logic [2:0]  comp_chan;
        logic        conv_start;
    } ctl_state_t;

endpackage : adc_pkg

`default_nettype wire

// ==== adc_clk_prescaler.sv ====
`default_nettype none

// Converter clock divider: one tick every 2^sel cycles, at least every 2
module adc_clk_prescaler
    import adc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    // Control
    input  wire logic       run_i,
    input  wire logic       restart_i,
    input  wire logic [2:0] div_sel_i,
    // Converter clock tick
    output logic            tick_o
);

    presc_state_t state_reg;
    presc_state_t state_next;
    logic   [6:0] last_cnt;

    // Divide ratio; 0 and 1 both give divide by two
    always_comb begin
        if (div_sel_i == 3'h0) begin
            last_cnt = 7'h01;
        end else begin
            last_cnt = 7'((8'h01 << div_sel_i) - 8'h01);
        end
    end

    // Held in reset while the converter is off, so the first tick is aligned
    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (!run_i || restart_i) begin
            state_next.cnt = 7'h00;
        end else if (state_reg.cnt >= last_cnt) begin
            state_next.cnt  = 7'h00;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + 7'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick_o = state_reg.tick;

endmodule : adc_clk_prescaler

`default_nettype wire

// ==== adc_conversion_control.sv ====
// How it works
// (R01) Comparator mux on and converter off: channel_select picks comparator negative input.
// (R02) Upper six bits of the pin input disable register read zero.
// (R03) A set pin disable bit forces that pin's read value to zero.
// (R04) Each conversion yields a 10-bit result over low and high bytes.
// (R05) Result right aligned, or left aligned when result_left_align is set.
// (R06) Reading low byte locks result until high byte read; locked results dropped.
// (R07) Completion sets the flag and raises the converter's own interrupt.
// (R08) The flag and interrupt still fire when a result is dropped.
// (R09) Channel and reference choices take effect only while converter is enabled.
// (R10) Software clears power reduction before enabling or starting the converter.
// (R11) start_conversion set by writing one, stays high, hardware clears at end.
// (R12) Channel changes during a conversion apply only after it finishes; in free running they wait until the free run ends.
// (R13) auto_trigger_enable starts conversions from the trigger picked by trigger_source_select.
// (R14) Trigger rising edge restarts the prescaler and starts a conversion.
// (R15) Edges during conversion ignored; a trigger still high at end starts nothing.
// (R16) Triggers are edges of source flags; sources must clear before rearming.
// (R17) Own completion flag as trigger: each end starts the next conversion.
// (R18) Software start works with auto trigger; start reads one while converting.
// (R19) Conversion lasts 13 converter clocks, the first after enable 25.
// (R20) At completion result stored, flag set, start cleared in single mode.
// (R21) comparator_mux_enable sits at bit 6 of control/status B.
// (R22) Analog core is a tick counter plus a result input port.
// (R23) Trigger source code zero selects own completion flag; others external inputs.
//
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none
`include "adc_map.svh"

module adc_conversion_control
    import adc_pkg::*;
#(
    parameter int TRIG_N = 7
)(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              nrst_i,
    // Register port
    input  wire reg_req_t          reg_req_i,
    output logic [7:0]             rdata_o,
    // Power reduction from the system controller
    input  wire logic              converter_power_reduction_i,
    // Hardware trigger sources, same clock domain
    input  wire logic [TRIG_N-1:0] trigger_i,
    // Analog core
    input  wire logic [9:0]        result_i,
    output logic                   conv_start_o,
    output logic                   busy_o,
    output logic [2:0]             conv_channel_o,
    output logic [1:0]             conv_reference_o,
    // Comparator negative input select
    output logic                   comp_neg_from_mux_o,
    output logic [2:0]             comp_neg_channel_o,
    // Comparator pins, digital side
    input  wire logic [1:0]        comp_pin_raw_i,
    output logic [1:0]             comp_pin_read_o,
    // Completion interrupt request
    output logic                   irq_o
);

    ctl_state_t s_reg;
    ctl_state_t s_next;
    logic       tick;
    logic       run;
    logic       restart_c;
    logic       trig_level;
    logic       trig_edge;
    logic       sw_start;
    logic [4:0] conv_len;
    logic [7:0] res_low;
    logic [7:0] res_high;
    logic [TRIG_N:0] trig_vec;

    // Converter clock; restarted by an accepted hardware trigger
    adc_clk_prescaler u_presc (
        .mclk_i    (mclk_i),
        .nrst_i    (nrst_i),
        .run_i     (run),
        .restart_i (restart_c),
        .div_sel_i (s_reg.psel),
        .tick_o    (tick)
    );

    // Converter runs only when enabled and not held in power reduction
    assign run = s_reg.en && !converter_power_reduction_i; // see (R10)

    // Trigger selection; code zero is the own completion flag
    assign trig_vec   = {trigger_i, s_reg.flag};                       // see (R23)
    assign trig_level = trig_vec[s_reg.tsel];                          // see (R13)
    assign trig_edge  = trig_level && !s_reg.trig_prev;                // see (R16)

    // Software start request, honoured with or without auto trigger
    assign sw_start = reg_req_i.wr && (reg_req_i.addr == `ADC_OFF_CTRL_A)
                      && reg_req_i.wdata[`ADC_A_START_BIT];            // see (R18)

    // First conversion after enable needs extra cycles for the analog side
    assign conv_len = s_reg.first ? `ADC_FIRST_CYCLES : `ADC_NORMAL_CYCLES; // see (R19)

    // Result alignment applied at read time, stored value stays raw
    always_comb begin
        if (s_reg.lar) begin // see (R05)
            res_high = s_reg.result[9:2];
            res_low  = {s_reg.result[1:0], 6'h00};
        end else begin
            res_high = {6'h00, s_reg.result[9:8]};
            res_low  = s_reg.result[7:0];
        end
    end

    // Next state of the whole block
    always_comb begin
        s_next            = s_reg;
        restart_c         = 1'b0;
        s_next.conv_start = 1'b0;

        // Pin synchroniser; first stage feeds only the second
        s_next.pin_s1 = comp_pin_raw_i;
        s_next.pin_s2 = s_reg.pin_s1;
        s_next.pin_read = s_reg.pin_s2 & ~s_reg.didr; // see (R03)

        // Register reads, answered one cycle later
        s_next.rdata = 8'h00;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                `ADC_OFF_CTRL_A: begin
                    s_next.rdata = {s_reg.en, s_reg.start, s_reg.ate, s_reg.flag,
                                    s_reg.ie, 2'b00, 1'b0} | {5'h00, s_reg.psel}; // see (R18)
                end
                `ADC_OFF_CTRL_B: begin
                    s_next.rdata = {1'b0, s_reg.comparator_mux_enable, 3'b000, s_reg.tsel}; // see (R21)
                end
                `ADC_OFF_MUX_SEL: begin
                    s_next.rdata = {s_reg.refsel, s_reg.lar, 2'b00, s_reg.chan};
                end
                `ADC_OFF_RESULT_LOW: begin
                    s_next.rdata = res_low;  // see (R04)
                    s_next.lock  = 1'b1;     // see (R06)
                end
                `ADC_OFF_RESULT_HIGH: begin
                    s_next.rdata = res_high; // see (R04)
                    s_next.lock  = 1'b0;     // see (R06)
                end
                `ADC_OFF_PIN_DISABLE: begin
                    s_next.rdata = {6'h00, s_reg.didr}; // see (R02)
                end
                default: begin
                    s_next.rdata = 8'h00;
                end
            endcase
        end

        // Register writes; the start bit is handled by the sequencer
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                `ADC_OFF_CTRL_A: begin
                    s_next.en   = reg_req_i.wdata[`ADC_A_ENABLE_BIT];
                    s_next.ate  = reg_req_i.wdata[`ADC_A_AUTO_BIT];
                    s_next.ie   = reg_req_i.wdata[`ADC_A_IRQ_EN_BIT];
                    s_next.psel = reg_req_i.wdata[`ADC_A_PRESC_LSB +: 3];
                    // Write one to clear; a set in the same cycle wins below
                    if (reg_req_i.wdata[`ADC_A_FLAG_BIT]) begin
                        s_next.flag = 1'b0;
                    end
                    if (!s_reg.en && reg_req_i.wdata[`ADC_A_ENABLE_BIT]) begin
                        s_next.first = 1'b1; // see (R19)
                    end
                end
                `ADC_OFF_CTRL_B: begin
                    s_next.comparator_mux_enable = reg_req_i.wdata[`ADC_B_COMP_MUX_BIT]; // see (R21)
                    s_next.tsel = reg_req_i.wdata[`ADC_B_TRIG_LSB +: 3];
                end
                `ADC_OFF_MUX_SEL: begin
                    s_next.refsel = reg_req_i.wdata[`ADC_M_REF_LSB +: 2];
                    s_next.lar    = reg_req_i.wdata[`ADC_M_LEFT_BIT];
                    s_next.chan   = reg_req_i.wdata[`ADC_M_CHAN_LSB +: 3];
                end
                `ADC_OFF_PIN_DISABLE: begin
                    s_next.didr = reg_req_i.wdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // Edge history runs always, so a level held through a conversion
        // never looks like a fresh edge afterwards
        s_next.trig_prev = trig_level; // see (R15)

        // Conversion sequencer
        if (!run) begin
            // Disabling aborts any conversion in flight
            s_next.st       = ST_IDLE;
            s_next.start    = 1'b0;
            s_next.tick_cnt = 5'h00;
        end else begin
            case (s_reg.st)
                ST_IDLE: begin
                    if (sw_start) begin
                        s_next.start = 1'b1; // see (R11)
                        s_next.st    = ST_ALIGN;
                    end else if (s_reg.ate && trig_edge) begin // see (R13)
                        restart_c         = 1'b1; // see (R14)
                        s_next.start      = 1'b1; // see (R18)
                        s_next.st         = ST_CONV;
                        s_next.tick_cnt   = 5'h00;
                        s_next.conv_start = 1'b1;
                    end
                end
                ST_ALIGN: begin
                    // Software starts line up with the next converter clock
                    if (tick) begin
                        s_next.st         = ST_CONV;
                        s_next.tick_cnt   = 5'h00;
                        s_next.conv_start = 1'b1;
                    end
                end
                ST_CONV: begin
                    // Further trigger edges are simply not looked at here
                    if (tick) begin // see (R15)
                        if (s_reg.tick_cnt == conv_len - 5'h01) begin // see (R19)
                            s_next.flag  = 1'b1; // see (R07) (R08) (R20)
                            s_next.first = 1'b0;
                            if (!s_next.lock) begin
                                s_next.result = result_i; // see (R06) (R20) (R22)
                            end
                            if (s_reg.ate && s_reg.tsel == `ADC_TRIG_SELF) begin
                                // Free running: next one starts at once
                                s_next.tick_cnt   = 5'h00; // see (R17)
                                s_next.conv_start = 1'b1;
                            end else begin
                                s_next.st    = ST_IDLE;
                                s_next.start = 1'b0; // see (R11) (R20)
                            end
                        end else begin
                            s_next.tick_cnt = s_reg.tick_cnt + 5'h01; // see (R22)
                        end
                    end
                end
                default: begin
                    s_next.st    = ST_IDLE;
                    s_next.start = 1'b0;
                end
            endcase
        end

        // Selections track software only while enabled and between
        // conversions; frozen during a conversion so sampling is stable
        if (s_reg.en && s_next.st != ST_CONV) begin // see (R09) (R12)
            s_next.chan_applied = s_next.chan;
            s_next.ref_applied  = s_next.refsel;
        end

        // Comparator negative input steering
        s_next.comp_mux  = s_next.comparator_mux_enable && !s_next.en; // see (R01)
        s_next.comp_chan = s_next.chan;               // see (R01)

        // Interrupt request from the sticky flag
        s_next.irq = s_next.flag && s_next.ie; // see (R07)
    end

    // State register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_reg        <= '0;
            s_reg.st     <= ST_IDLE;
            s_reg.result <= `ADC_RST_RESULT;
            s_reg.rdata  <= `ADC_RST_BYTE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign rdata_o             = s_reg.rdata;
    assign conv_start_o        = s_reg.conv_start;
    assign busy_o              = s_reg.start;
    assign conv_channel_o      = s_reg.chan_applied;
    assign conv_reference_o    = s_reg.ref_applied;
    assign comp_neg_from_mux_o = s_reg.comp_mux;
    assign comp_neg_channel_o  = s_reg.comp_chan;
    assign comp_pin_read_o     = s_reg.pin_read;
    assign irq_o               = s_reg.irq;

endmodule : adc_conversion_control

`default_nettype wire

// ==== adc_conversion_control_asserts.sv ====
`default_nettype none

// Port-level checker for the conversion control block
module adc_conversion_control_chk
    import adc_pkg::*;
#(
    parameter int TRIG_N = 7
)(
    // Clock and reset
    input wire logic              mclk_i,
    input wire logic              nrst_i,
    // Register port
    input wire reg_req_t          reg_req_i,
    input wire logic [7:0]        rdata_o,
    // Converter side
    input wire logic              converter_power_reduction_i,
    input wire logic [TRIG_N-1:0] trigger_i,
    input wire logic [9:0]        result_i,
    input wire logic              conv_start_o,
    input wire logic              busy_o,
    input wire logic [2:0]        conv_channel_o,
    input wire logic [1:0]        conv_reference_o,
    // Comparator side
    input wire logic              comp_neg_from_mux_o,
    input wire logic [2:0]        comp_neg_channel_o,
    input wire logic [1:0]        comp_pin_raw_i,
    input wire logic [1:0]        comp_pin_read_o,
    input wire logic              irq_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    // Read data only in the answer cycle
    property p_rdata_idle;
        !$past(reg_req_i.rd) |-> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside answer cycle");

    property p_pin_reserved;
        reg_req_i.rd && reg_req_i.addr == 3'h5 |=> rdata_o[7:2] == 6'h00;
    endproperty
    a_pin_reserved: assert property (p_pin_reserved)
        else $error("reserved pin disable bits not zero");

    // Converter running means it is enabled, so no mux steering
    property p_mux_busy;
        busy_o |-> !comp_neg_from_mux_o;
    endproperty
    a_mux_busy: assert property (p_mux_busy)
        else $error("comparator mux steered while converting");

    // Minimum conversion is 13 ticks of at least 2 cycles
    property p_busy_hold;
        conv_start_o |=> busy_o [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped early in a conversion");

    property p_start_gap;
        conv_start_o |=> !conv_start_o [*8];
    endproperty
    a_start_gap: assert property (p_start_gap)
        else $error("second start during a conversion");

    property p_sel_frozen;
        conv_start_o |=> ($stable(conv_channel_o) && $stable(conv_reference_o)) [*8];
    endproperty
    a_sel_frozen: assert property (p_sel_frozen)
        else $error("selection changed during conversion");

    property p_pin_off;
        reg_req_i.wr && reg_req_i.addr == 3'h5
            |-> ##2 (comp_pin_read_o & $past(reg_req_i.wdata[1:0], 2)) == 2'b00;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("disabled pin reads nonzero");

    property p_pr_off;
        converter_power_reduction_i && $past(converter_power_reduction_i) |-> !conv_start_o;
    endproperty
    a_pr_off: assert property (p_pr_off)
        else $error("conversion began while held off");

    c_start: cover property (conv_start_o);
    c_irq: cover property ($rose(irq_o));
    c_mux: cover property (comp_neg_from_mux_o);
endmodule : adc_conversion_control_chk

bind adc_conversion_control adc_conversion_control_chk #(.TRIG_N(TRIG_N)) chk_inst (
    .mclk_i, .nrst_i, .reg_req_i, .rdata_o, .converter_power_reduction_i, .trigger_i,
    .result_i, .conv_start_o, .busy_o, .conv_channel_o, .conv_reference_o,
    .comp_neg_from_mux_o, .comp_neg_channel_o, .comp_pin_raw_i, .comp_pin_read_o, .irq_o
);

`default_nettype wire

// ==== tb_adc_conversion_control.sv ====
`default_nettype none

module tb_adc_conversion_control
    import adc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       mclk_i = 1'b0;
    logic       nrst_i = 1'b0;
    reg_req_t   reg_req_i = '0;
    logic [7:0] rdata_o;
    logic       converter_power_reduction_i = 1'b0;
    logic [6:0] trigger_i = '0;
    logic [9:0] result_i = '0;
    logic       conv_start_o, busy_o, comp_neg_from_mux_o, irq_o;
    logic [2:0] conv_channel_o, comp_neg_channel_o;
    logic [1:0] conv_reference_o, comp_pin_read_o;
    logic [1:0] comp_pin_raw_i = 2'b11;
    int         n_fail = 0;
    int         n_compared = 0;
    int         cycles = 0;
    int         n_starts = 0;
    int         s;

    adc_conversion_control adc_conversion_control_inst (
        .mclk_i, .nrst_i, .reg_req_i, .rdata_o, .converter_power_reduction_i, .trigger_i,
        .result_i, .conv_start_o, .busy_o, .conv_channel_o, .conv_reference_o,
        .comp_neg_from_mux_o, .comp_neg_channel_o, .comp_pin_raw_i, .comp_pin_read_o, .irq_o
    );

    always #10 mclk_i = ~mclk_i;

    // Start counter and hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (conv_start_o === 1'b1) n_starts++;
        if (cycles > 6000) begin
            n_fail++;
            summarize();
        end
    end

    task automatic summarize();
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    // One-cycle write strobe, released at the taking edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_req_i.addr <= a;
        reg_req_i.wdata <= d;
        reg_req_i.wr <= 1'b1;
        @(posedge mclk_i);
        reg_req_i.wr <= 1'b0;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_req_i.addr <= a;
        reg_req_i.rd <= 1'b1;
        @(posedge mclk_i);
        reg_req_i.rd <= 1'b0;
        @(negedge mclk_i);
        chk($sformatf("reg %0d", a), {2'b00, exp}, {2'b00, rdata_o});
    endtask : rchk

    task automatic wait_done();
        int k;
        k = 0;
        @(negedge mclk_i);
        while (busy_o === 1'b1 && k < 300) begin
            @(negedge mclk_i);
            k++;
        end
        chk("busy end", 10'h000, {9'h000, busy_o});
    endtask : wait_done

    task automatic idle(input int n, input int exp_starts);
        repeat (n) @(negedge mclk_i);
        chk("starts", 10'(exp_starts), 10'(n_starts - s));
    endtask : idle

    initial begin
        repeat (3) @(posedge mclk_i);
        nrst_i <= 1'b1;
        // Reset values and an unmapped index
        for (int a = 0; a < 7; a++) rchk(a[2:0], 8'h00); // reset
        wr(3'h5, 8'hFF);
        rchk(3'h5, 8'h03); // reserved
        repeat (4) @(negedge mclk_i);
        chk("pin read", 10'h000, {8'h00, comp_pin_read_o}); // both off
        wr(3'h5, 8'h01);
        repeat (4) @(negedge mclk_i);
        chk("pin read", 10'h002, {8'h00, comp_pin_read_o}); // one off
        // Comparator steering while the converter is off
        wr(3'h2, 8'h05);
        wr(3'h1, 8'h40);
        repeat (2) @(negedge mclk_i);
        chk("comp mux", 10'h001, {9'h0, comp_neg_from_mux_o}); // steered
        chk("comp chan", 10'h005, {7'h0, comp_neg_channel_o}); // channel
        chk("conv chan", 10'h000, {7'h0, conv_channel_o}); // not applied
        wr(3'h0, 8'h88);
        repeat (2) @(negedge mclk_i);
        chk("comp mux", 10'h000, {9'h0, comp_neg_from_mux_o}); // released
        chk("conv chan", 10'h005, {7'h0, conv_channel_o}); // applied
        // Start refused while held off
        converter_power_reduction_i <= 1'b1;
        wr(3'h0, 8'hC8);
        repeat (4) @(negedge mclk_i);
        chk("busy held off", 10'h000, {9'h0, busy_o}); // refused
        converter_power_reduction_i <= 1'b0;
        // Single conversion, right aligned
        result_i <= 10'h2A5;
        wr(3'h0, 8'hC8);
        rchk(3'h0, 8'hC8); // busy bit
        wait_done();
        rchk(3'h0, 8'h98); // flag set
        chk("irq", 10'h001, {9'h0, irq_o}); // raised
        rchk(3'h3, 8'hA5); // low byte
        rchk(3'h4, 8'h02); // high byte
        // Channel change mid conversion, then left aligned readout
        wr(3'h0, 8'hD8);
        wr(3'h2, 8'hA6);
        chk("conv chan", 10'h005, {7'h0, conv_channel_o}); // held
        wait_done();
        @(negedge mclk_i);
        chk("conv chan", 10'h006, {7'h0, conv_channel_o}); // applied after
        chk("conv ref", 10'h002, {8'h0, conv_reference_o}); // applied after
        rchk(3'h3, 8'h40); // left low
        rchk(3'h4, 8'hA9); // left high
        // Low byte read locks the pair; completion still flags
        rchk(3'h3, 8'h40);
        result_i <= 10'h3FF;
        wr(3'h0, 8'hD8);
        wait_done();
        rchk(3'h0, 8'h98); // flag on drop
        chk("irq", 10'h001, {9'h0, irq_o}); // fires on drop
        rchk(3'h4, 8'hA9); // old pair kept
        wr(3'h0, 8'hC8);
        wait_done();
        rchk(3'h3, 8'hC0); // unlocked
        rchk(3'h4, 8'hFF); // new pair
        wr(3'h0, 8'h98);
        @(negedge mclk_i);
        chk("irq", 10'h000, {9'h0, irq_o}); // cleared
        // Every external trigger source
        wr(3'h2, 8'h00);
        for (int k = 1; k < 8; k++) begin
            wr(3'h1, k[7:0]);
            wr(3'h0, 8'hB8);
            s = n_starts;
            @(posedge mclk_i);
            trigger_i[k-1] <= 1'b1;
            rchk(3'h0, 8'hE8); // busy on trigger
            trigger_i[k-1] <= 1'b0;
            repeat (2) @(posedge mclk_i);
            trigger_i[k-1] <= 1'b1;
            wait_done();
            idle(30, 1); // one start only
            @(posedge mclk_i);
            trigger_i[k-1] <= 1'b0;
        end
        // Software start with auto triggering enabled
        s = n_starts;
        wr(3'h0, 8'hE8);
        wait_done();
        idle(30, 1); // single start
        // Own flag as source: free running without clearing the flag
        wr(3'h1, 8'h00);
        s = n_starts;
        wr(3'h0, 8'hE8);
        repeat (150) @(negedge mclk_i);
        chk("free run", 10'h001, {9'h0, (n_starts - s >= 4)}); // restarts
        wr(3'h0, 8'h88);
        wait_done();
        summarize();
    end
endmodule : tb_adc_conversion_control

`default_nettype wire
